// [logic/fcap_core.sv]
// Serial flash command acceptance, write-enable latch and write protection
`timescale 1ns/10ps

module fcap_core import fcap_pkg::*; #(
	parameter int POWERUP_CYCLES = POWERUP_WRITE_CYCLES
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Serial pins from the host
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_serial_in,
	input wire logic i_write_protect_n,
	// Internal engine completion
	input wire logic i_cycle_done,
	// Serial output pin
	output logic o_serial_out,
	output logic o_serial_out_en,
	// Status
	output logic o_busy_flag,
	output logic o_write_enable_latch,
	output logic [3:0] o_protect_field,
	output logic o_status_protect_bit,
	output logic o_hardware_protected_mode,
	output logic o_deep_sleep,
	output logic o_powerup_done,
	// Accepted operation for the engine
	output logic o_exec_valid,
	output logic [7:0] o_exec_cmd,
	output logic [23:0] o_exec_addr,
	output logic o_prog_byte_valid,
	output logic [7:0] o_prog_byte
);

	////////////////////////////////////////////////////////////////////////
	// Protection decode
	function automatic logic fcap_protected(input logic [3:0] code, input logic [2:0] blk);
		logic [3:0] eighths;
		eighths = 4'h0;
		case (code[2:0])
			3'h1: eighths = 4'h1;
			3'h2: eighths = 4'h2;
			3'h3: eighths = 4'h4;
			3'h4: eighths = 4'h6;
			3'h5: eighths = 4'h7;
			3'h6: eighths = 4'h8;
			3'h7: eighths = 4'h8;
			default: eighths = 4'h0;
		endcase
		// Upper fractions count down from the top, lower ones up from zero
		if (code[3]) begin
			fcap_protected = {1'b0, blk} < eighths;
		end else begin
			fcap_protected = {1'b0, blk} >= (4'h8 - eighths);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: cs, clk, data, protect pin
	logic [3:0] pin_s1; // First stage, read only by second
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_filt; // Accepted pin levels
	logic [3:0] pin_prev; // Previous accepted levels

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_s1 <= 4'h9;
			pin_s2 <= 4'h9;
			pin_s3 <= 4'h9;
			pin_filt <= 4'h9;
			pin_prev <= 4'h9;
		end else if (i_ce) begin
			pin_s1 <= {i_write_protect_n, i_serial_in, i_sclk, i_cs_n};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < 4; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_filt[i] <= pin_s3[i];
				end
			end
			pin_prev <= pin_filt;
		end
	end

	logic cs_n;
	logic din;
	logic wp_n;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	assign cs_n = pin_filt[0];
	assign din = pin_filt[2];
	assign wp_n = pin_filt[3];
	assign sclk_rise = pin_filt[1] & ~pin_prev[1] & ~cs_n;
	assign sclk_fall = ~pin_filt[1] & pin_prev[1] & ~cs_n;
	assign cs_rise = cs_n & ~pin_prev[0];
	assign cs_fall = ~cs_n & pin_prev[0];

	////////////////////////////////////////////////////////////////////////
	// Input shifter
	logic [15:0] bit_cnt; // Rising edges since select fell, saturating
	logic [6:0] shreg; // Partial byte
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [7:0] status_byte_in; // Second byte, status write payload
	logic [7:0] next_byte;
	logic byte_done;
	assign next_byte = {shreg, din};
	assign byte_done = sclk_rise & (bit_cnt[2:0] == 3'h7);

	// Bits enter MSB first on each rising clock edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt <= 16'h0000;
			shreg <= 7'h00;
		end else if (i_ce) begin
			if (cs_fall) begin
				bit_cnt <= 16'h0000;
			end else if (sclk_rise) begin
				shreg <= next_byte[6:0];
				if (bit_cnt != 16'hffff) begin
					bit_cnt <= bit_cnt + 16'h0001;
				end
			end
		end
	end

	// First byte is the opcode, then three address bytes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			opcode <= 8'h00;
			addr <= 24'h000000;
			status_byte_in <= 8'h00;
		end else if (i_ce && byte_done) begin
			case (bit_cnt[15:3])
				13'h0000: opcode <= next_byte;
				13'h0001: begin
					addr[23:16] <= next_byte;
					status_byte_in <= next_byte;
				end
				13'h0002: addr[15:8] <= next_byte;
				13'h0003: addr[7:0] <= next_byte;
				default: ;
			endcase
		end
	end

	// Program data streams to the engine, committed only by o_exec_valid
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prog_byte_valid <= 1'b0;
			o_prog_byte <= 8'h00;
		end else if (i_ce) begin
			o_prog_byte_valid <= byte_done && (bit_cnt[15:3] >= 13'h0004) && !o_busy_flag && !o_deep_sleep
				&& (opcode == OP_PAGE_PROGRAM || opcode == OP_QUAD_PAGE_PROGRAM);
			if (byte_done) begin
				o_prog_byte <= next_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up write timer
	logic [31:0] puw_cnt;

	// Modifications stay refused until this runs out
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			puw_cnt <= 32'h00000000;
			o_powerup_done <= 1'b0;
		end else if (i_ce && !o_powerup_done) begin
			puw_cnt <= puw_cnt + 32'h00000001;
			o_powerup_done <= (puw_cnt >= 32'(POWERUP_CYCLES - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acceptance decision at select rising
	logic aligned;
	logic may_modify;
	logic addr_prot;
	logic any_prot;
	logic is_program;
	logic is_erase;
	assign aligned = (bit_cnt[2:0] == 3'h0) && (bit_cnt != 16'h0000);
	assign may_modify = o_write_enable_latch && o_powerup_done && !o_busy_flag;
	assign addr_prot = fcap_protected(o_protect_field, addr[BLOCK_MSB:BLOCK_LSB]);
	assign any_prot = (o_protect_field[2:0] != 3'h0);
	assign is_program = (opcode == OP_PAGE_PROGRAM) || (opcode == OP_QUAD_PAGE_PROGRAM);
	assign is_erase = (opcode == OP_SECTOR_ERASE) || (opcode == OP_HALF_BLOCK_ERASE) || (opcode == OP_BLOCK_ERASE);

	logic accept_status_write;
	logic accept_program;
	logic accept_erase;
	logic accept_chip_erase;
	logic deep_gate; // Nothing but wake passes deep sleep
	assign deep_gate = cs_rise && !o_deep_sleep;
	assign accept_status_write = deep_gate && aligned && may_modify && opcode == OP_STATUS_WRITE
		&& bit_cnt >= BITS_STATUS_WRITE;
	// Partial last byte fails 'aligned', so the latch stays set
	assign accept_program = deep_gate && aligned && may_modify && is_program
		&& bit_cnt >= BITS_PROGRAM_MIN && !addr_prot;
	assign accept_erase = deep_gate && may_modify && is_erase && bit_cnt == BITS_ERASE_EXACT && !addr_prot;
	assign accept_chip_erase = deep_gate && aligned && may_modify && !any_prot
		&& (opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B);

	logic start_cycle;
	assign start_cycle = accept_status_write | accept_program | accept_erase | accept_chip_erase;

	// Write-enable latch
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_write_enable_latch <= 1'b0;
		end else if (i_ce && deep_gate && aligned && !o_busy_flag) begin
			if (opcode == OP_WRITE_ENABLE) begin
				o_write_enable_latch <= 1'b1;
			end else if (opcode == OP_WRITE_DISABLE || start_cycle) begin
				o_write_enable_latch <= 1'b0;
			end
		end else if (i_ce && accept_erase) begin
			o_write_enable_latch <= 1'b0;
		end
	end

	// Busy flag across the internal cycle; completion ends it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy_flag <= 1'b0;
		end else if (i_ce) begin
			if (start_cycle) begin
				o_busy_flag <= 1'b1;
			end else if (i_cycle_done) begin
				o_busy_flag <= 1'b0;
			end
		end
	end

	// Operation hand-off to the engine
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_exec_valid <= 1'b0;
			o_exec_cmd <= 8'h00;
			o_exec_addr <= 24'h000000;
		end else if (i_ce) begin
			o_exec_valid <= start_cycle;
			if (start_cycle) begin
				o_exec_cmd <= opcode;
				o_exec_addr <= addr;
			end
		end
	end

	// Hardware mode follows the protect bit and the pin
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hardware_protected_mode <= 1'b0;
		end else if (i_ce) begin
			o_hardware_protected_mode <= o_status_protect_bit && !wp_n;
		end
	end

	// Protection bits; a status write refused by the protect bit and pin still clears the latch and raises busy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_protect_field <= PROTECT_FIELD_RESET;
			o_status_protect_bit <= STATUS_PROTECT_RESET;
		end else if (i_ce && accept_status_write && !(o_status_protect_bit && !wp_n)) begin
			o_protect_field <= status_byte_in[ST_BP_HI:ST_BP_LO];
			o_status_protect_bit <= status_byte_in[ST_SRP];
		end
	end

	// Deep sleep entry and wake
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_deep_sleep <= 1'b0;
		end else if (i_ce && cs_rise) begin
			if (opcode == OP_WAKE && bit_cnt >= BITS_OPCODE) begin
				o_deep_sleep <= 1'b0;
			end else if (deep_gate && aligned && opcode == OP_DEEP_SLEEP && !o_busy_flag) begin
				o_deep_sleep <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data-out phase: status repeats, or the identifier after wake
	logic out_active;
	logic out_is_id;
	logic [2:0] out_bit;
	logic [7:0] status_now;
	logic [7:0] out_byte;
	assign status_now = {o_status_protect_bit, 1'b0, o_protect_field, o_write_enable_latch, o_busy_flag};
	assign out_byte = out_is_id ? DEVICE_ID_VALUE : status_now;

	// Starts after the input part; select rising ends it at any bit
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_active <= 1'b0;
			out_is_id <= 1'b0;
		end else if (i_ce) begin
			if (cs_n) begin
				out_active <= 1'b0;
			end else if (byte_done && bit_cnt == 16'h0007 && next_byte == OP_STATUS_READ && !o_deep_sleep) begin
				out_active <= 1'b1;
				out_is_id <= 1'b0;
			end else if (byte_done && bit_cnt == BITS_WAKE_ID - 16'h0001 && opcode == OP_WAKE) begin
				out_active <= 1'b1;
				out_is_id <= 1'b1;
			end
		end
	end

	// Bits leave MSB first on falling clock edges
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_bit <= 3'h0;
			o_serial_out <= 1'b0;
			o_serial_out_en <= 1'b0;
		end else if (i_ce) begin
			if (!out_active) begin
				out_bit <= 3'h0;
				o_serial_out_en <= 1'b0;
			end else if (sclk_fall) begin
				o_serial_out <= out_byte[3'h7 - out_bit];
				o_serial_out_en <= 1'b1;
				out_bit <= out_bit + 3'h1;
			end
		end
	end

endmodule

// [logic/fcap_pkg.sv]
// Constants shared by the flash command acceptance and protection block
package fcap_pkg;
	// Opcodes that this block decodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	// Bit counts of a sequence (opcode included)
	localparam logic [15:0] BITS_OPCODE = 16'h0008;
	localparam logic [15:0] BITS_STATUS_WRITE = 16'h0010;
	localparam logic [15:0] BITS_ERASE_EXACT = 16'h0020;
	localparam logic [15:0] BITS_PROGRAM_MIN = 16'h0028;
	localparam logic [15:0] BITS_WAKE_ID = 16'h0020;
	// Status byte layout
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 5;
	localparam int ST_SRP = 7;
	// Reset values of the protection bits
	localparam logic [3:0] PROTECT_FIELD_RESET = 4'h0;
	localparam logic STATUS_PROTECT_RESET = 1'b0;
	// Device identifier returned after wake; arbitrary value
	localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;
	// Block index of the address: 64 KB blocks in 512 KB
	localparam int BLOCK_MSB = 18;
	localparam int BLOCK_LSB = 16;
	// Power-up write delay and its cycle count at 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int POWERUP_WRITE_DELAY_US = 1000;
	localparam int POWERUP_WRITE_CYCLES = POWERUP_WRITE_DELAY_US * CLK_MHZ;
endpackage

// [test/fcap_core_sva.sv]
// Port assertions for the flash command acceptance block
`timescale 1ns/10ps
module fcap_core_sva import fcap_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Engine completion
	input wire logic i_cycle_done,
	// Status outputs
	input wire logic o_busy_flag,
	input wire logic o_write_enable_latch,
	input wire logic [3:0] o_protect_field,
	input wire logic o_status_protect_bit,
	input wire logic o_hardware_protected_mode,
	input wire logic o_deep_sleep,
	input wire logic o_powerup_done,
	// Accepted operation
	input wire logic o_exec_valid,
	input wire logic [7:0] o_exec_cmd,
	input wire logic [23:0] o_exec_addr
);
	// Opcodes that start an internal cycle
	function automatic logic is_mod(logic [7:0] c);
		return c inside {OP_STATUS_WRITE, OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_SECTOR_ERASE,
			OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
	endfunction
	// Block inside the region of a protect code; bit 3 picks the lower end
	function automatic logic is_prot(logic [3:0] f, logic [2:0] b);
		logic [3:0] n;
		case (f[2:0])
			3'h0: n = 4'h0;
			3'h1: n = 4'h1;
			3'h2: n = 4'h2;
			3'h3: n = 4'h4;
			3'h4: n = 4'h6;
			3'h5: n = 4'h7;
			default: n = 4'h8;
		endcase
		return f[3] ? ({1'b0, b} < n) : ({1'b0, b} >= 4'h8 - n);
	endfunction
	// Accept of a modifying operation
	logic acc;
	assign acc = o_exec_valid && is_mod(o_exec_cmd);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_wel_needed: assert property (acc |-> $past(o_write_enable_latch))
		else $error("modify accepted without latch");
	a_wel_cleared: assert property (acc |-> !o_write_enable_latch)
		else $error("latch kept after accept");
	a_busy_set: assert property (acc |-> o_busy_flag)
		else $error("busy not raised");
	a_busy_holds: assert property (o_busy_flag && !i_cycle_done |=> o_busy_flag)
		else $error("busy dropped early");
	a_busy_ignores: assert property (acc |-> !$past(o_busy_flag))
		else $error("accepted while busy");
	a_powerup_gate: assert property (acc |-> $past(o_powerup_done))
		else $error("accepted before power-up delay");
	a_region_safe: assert property (acc && o_exec_cmd != OP_STATUS_WRITE |->
		((o_exec_cmd == OP_CHIP_ERASE_A || o_exec_cmd == OP_CHIP_ERASE_B) ? o_protect_field[2:0] == 3'h0 :
		!is_prot(o_protect_field, o_exec_addr[BLOCK_MSB:BLOCK_LSB])))
		else $error("protected region modified");
	a_hpm_freeze: assert property (o_hardware_protected_mode |=>
		$stable(o_protect_field) && $stable(o_status_protect_bit))
		else $error("protection bits changed in hardware mode");
	a_sleep_gate: assert property (o_exec_valid && $past(o_deep_sleep) |-> o_exec_cmd == OP_WAKE)
		else $error("accepted while asleep");
endmodule
bind fcap_core fcap_core_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_cycle_done(i_cycle_done),
	.o_busy_flag(o_busy_flag), .o_write_enable_latch(o_write_enable_latch), .o_protect_field(o_protect_field),
	.o_status_protect_bit(o_status_protect_bit), .o_hardware_protected_mode(o_hardware_protected_mode),
	.o_deep_sleep(o_deep_sleep), .o_powerup_done(o_powerup_done), .o_exec_valid(o_exec_valid),
	.o_exec_cmd(o_exec_cmd), .o_exec_addr(o_exec_addr));

// [test/fcap_host_model.sv]
// Serial host model driving select, clock and data in
`timescale 1ns/10ps
module fcap_host_model (
	// System clock for timing
	input wire logic i_clk,
	// Data coming back from the device
	input wire logic i_serial_out,
	// Serial pins toward the device
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_serial_in
);
	// Last eight bits seen on the data-out pin at clock rises
	logic [7:0] rx;
	// Idle: deselected, clock parked low
	initial begin
		rx = 8'h00;
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_serial_in = 1'b0;
	end
	// Half of the 160 ns link period
	task automatic half;
		repeat (8) @(posedge i_clk);
		#1;
	endtask
	// One frame of n bits, top bit first
	task automatic send(input logic [47:0] v, input int n);
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_serial_in = v[i];
			half;
			o_sclk = 1'b1;
			rx = {rx[6:0], i_serial_out};
			half;
			o_sclk = 1'b0;
		end
		half;
		o_cs_n = 1'b1;
		o_serial_in = ~o_serial_in; // Released line must not look held
		half;
	endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the command acceptance block
`timescale 1ns/10ps
module tb_top;
	import fcap_pkg::*;
	logic i_clk, i_rst, wp_n, cdone, cs_n, sclk, sdi;
	logic busy, write_enable_latch, status_protect_bit, hardware_protected_mode, sleep, pwr, sout;
	logic [3:0] field, f;
	logic [7:0] cmd, d;
	logic [23:0] addr, pbyte, a;
	logic [2:0] b;
	int n_mismatch, compares;
	// Clock at 100 MHz
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	fcap_host_model host (.i_clk(i_clk), .i_serial_out(sout), .o_cs_n(cs_n), .o_sclk(sclk), .o_serial_in(sdi));
	// Short power-up delay keeps the run brief
	fcap_core #(.POWERUP_CYCLES(20)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_serial_in(sdi), .i_write_protect_n(wp_n), .i_cycle_done(cdone), .o_serial_out(sout),
		.o_serial_out_en(), .o_busy_flag(busy), .o_write_enable_latch(write_enable_latch), .o_protect_field(field),
		.o_status_protect_bit(status_protect_bit), .o_hardware_protected_mode(hardware_protected_mode), .o_deep_sleep(sleep),
		.o_powerup_done(pwr), .o_exec_valid(), .o_exec_cmd(cmd), .o_exec_addr(addr),
		.o_prog_byte_valid(), .o_prog_byte(pbyte[7:0]));
	assign pbyte[23:8] = 16'h0000;
	// Protected blocks of a code
	function automatic logic prot(logic [3:0] c, logic [2:0] k);
		logic [3:0] n;
		n = (c[2:0] == 3'h3) ? 4'h4 : (c[2:0] == 3'h4) ? 4'h6 : (c[2:0] == 3'h5) ? 4'h7 :
			(c[2:0] > 3'h5) ? 4'h8 : {1'b0, c[2:0]};
		return c[3] ? ({1'b0, k} < n) : ({1'b0, k} >= 4'h8 - n);
	endfunction
	task chkb(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t flag %b want %b", $time, g, e);
		end
	endtask
	task chkv(input logic [23:0] g, input logic [23:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t value %h want %h", $time, g, e);
		end
	endtask
	task end_sim;
		if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Frame, then time for the decision to land
	task op(input logic [47:0] v, input int n);
		host.send(v, n);
		repeat (6) @(posedge i_clk);
		#1;
	endtask
	// Engine finishes its cycle
	task done;
		cdone = 1'b1;
		@(posedge i_clk);
		#1 cdone = 1'b0;
	endtask
	// Enable then status write
	task wsr(input logic s, input logic [3:0] c);
		op(48'h06, 8);
		op({32'h0, OP_STATUS_WRITE, s, 1'b0, c, 2'b00}, 16);
		done;
	endtask
	initial begin
		n_mismatch = 0;
		compares = 0;
		i_rst = 1'b1;
		wp_n = 1'b1;
		cdone = 1'b0;
		void'($urandom(32'h467a8ad3));
		repeat (12) @(posedge i_clk);
		#1 i_rst = 1'b0;
		chkb(write_enable_latch, 1'b0);
		for (int k = 0; k < 100 && pwr !== 1'b1; k++) @(posedge i_clk);
		chkb(pwr, 1'b1);
		if (pwr !== 1'b1) end_sim;
		#1 op(48'h06, 8);
		chkb(write_enable_latch, 1'b1);
		op(48'h04, 8);
		chkb(write_enable_latch, 1'b0);
		a = 24'($urandom);
		d = 8'($urandom);
		op({8'h0, OP_PAGE_PROGRAM, a, d}, 40);
		chkb(busy, 1'b0);
		op(48'h06, 8);
		op({8'h0, OP_PAGE_PROGRAM, a, d} >> 1, 39);
		chkb(busy, 1'b0);
		chkb(write_enable_latch, 1'b1);
		op({16'h0, OP_PAGE_PROGRAM, a}, 32);
		chkb(busy, 1'b0);
		op({8'h0, OP_SECTOR_ERASE, a, 8'h00}, 40);
		chkb(busy, 1'b0);
		op({8'h0, OP_PAGE_PROGRAM, a, d}, 40);
		chkb(busy, 1'b1);
		chkb(write_enable_latch, 1'b0);
		chkv(24'(cmd), 24'(OP_PAGE_PROGRAM));
		chkv(addr, a);
		chkv(pbyte, 24'(d));
		op(48'h06, 8);
		chkb(write_enable_latch, 1'b0);
		done;
		chkb(busy, 1'b0);
		// Every protect code twice, random block
		for (int k = 0; k < 32; k++) begin
			f = 4'(k);
			b = 3'($urandom);
			wsr(1'b0, f);
			chkv(24'(field), 24'(f));
			op(48'h06, 8);
			op({16'h0, OP_BLOCK_ERASE, 5'h00, b, 16'($urandom)}, 32);
			chkb(busy, !prot(f, b));
			if (busy === 1'b1) done;
		end
		// Chip erase refused while any protect code is set
		op(48'h06, 8);
		op({40'h0, OP_CHIP_ERASE_A}, 8);
		chkb(busy, 1'b0);
		wsr(1'b1, 4'h0);
		wp_n = 1'b0;
		repeat (8) @(posedge i_clk);
		#1 chkb(hardware_protected_mode, 1'b1);
		wsr(1'b0, 4'h3);
		chkv(24'(field), 24'h0);
		chkb(status_protect_bit, 1'b1);
		wp_n = 1'b1;
		repeat (8) @(posedge i_clk);
		#1 chkb(hardware_protected_mode, 1'b0);
		wsr(1'b0, 4'h0);
		chkb(status_protect_bit, 1'b0);
		// Status read: protect bit 0, field 0, latch 1, idle
		op(48'h06, 8);
		op({32'h0, OP_STATUS_READ, 8'h00}, 16);
		chkv(24'(host.rx), 24'h000002);
		op({40'h0, OP_DEEP_SLEEP}, 8);
		chkb(sleep, 1'b1);
		op(48'h04, 8);
		chkb(write_enable_latch, 1'b1);
		op({40'h0, OP_WAKE}, 8);
		chkb(sleep, 1'b0);
		// Chip erase with nothing protected
		op(48'h06, 8);
		op({40'h0, OP_CHIP_ERASE_B}, 8);
		chkb(busy, 1'b1);
		done;
		end_sim;
	end
endmodule
